// ===== core/ddl_lane.sv
// Purpose: Data lanes, strobes, mask/inversion and refresh timing of a DRAM
// Assumes: true_clock_input is slow against clk and is sampled like any pin
// Notes: Small array model; one beat per command; mode bits are pins
`timescale 1ns/1ns
module ddl_lane
    import ddl_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Die reset pin, active low
    input wire logic reset_pin_n,
    // Link clock pair
    input wire logic true_clock_input,
    input wire logic complement_clock_input,
    // Command and address
    input wire logic [2:0] cmd,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ADDR_WIDTH-1:0] addr,
    // Mode settings
    input wire logic bus_inversion_en,
    input wire logic write_mask_en,
    // Data pins
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic [DATA_W-1:0] dq_oe,
    // Strobe pairs
    input wire logic [LANES-1:0] dqs_t_in,
    input wire logic [LANES-1:0] dqs_c_in,
    output logic [LANES-1:0] dqs_t_out,
    output logic [LANES-1:0] dqs_c_out,
    output logic [LANES-1:0] dqs_oe,
    // Mask/inversion lines
    input wire logic [LANES-1:0] mask_inversion_line_in,
    output logic [LANES-1:0] mask_inversion_line_out,
    output logic [LANES-1:0] mask_inversion_line_oe,
    // Status
    output logic allbank_busy,
    output logic [BANKS-1:0] bank_busy,
    output logic timing_violation
);
    // Two-stage synchronisers for every pin input except the strobe pair inputs, which are not used
    logic [1:0] ck_t_s;
    logic [1:0] ck_c_s;
    logic [1:0] rstn_s;
    logic ck_t_d;
    logic [2:0] cmd_s1, cmd_s2;
    logic [BANK_W-1:0] bank_s1, bank_s2;
    logic [ADDR_WIDTH-1:0] addr_s1, addr_s2;
    logic [DATA_W-1:0] dq_s1, dq_s2;
    logic [LANES-1:0] mi_s1, mi_s2;
    logic [1:0] mode_s1, mode_s2;
    logic die_rst;
    logic ck_rise;
    ddl_cmd_t cmd_now;

    always_ff @(posedge clk) begin
        if (rst) begin
            ck_t_s <= 2'h0;
            ck_c_s <= 2'h3;
            rstn_s <= 2'h0;
            ck_t_d <= 1'b0;
            cmd_s1 <= 3'h0;
            cmd_s2 <= 3'h0;
            bank_s1 <= '0;
            bank_s2 <= '0;
            addr_s1 <= '0;
            addr_s2 <= '0;
            dq_s1 <= '0;
            dq_s2 <= '0;
            mi_s1 <= '0;
            mi_s2 <= '0;
            mode_s1 <= 2'h0;
            mode_s2 <= 2'h0;
        end else begin
            ck_t_s <= {ck_t_s[0], true_clock_input};
            ck_c_s <= {ck_c_s[0], complement_clock_input};
            rstn_s <= {rstn_s[0], reset_pin_n};
            ck_t_d <= ck_t_s[1];
            cmd_s1 <= cmd;
            cmd_s2 <= cmd_s1;
            bank_s1 <= bank;
            bank_s2 <= bank_s1;
            addr_s1 <= addr;
            addr_s2 <= addr_s1;
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            mi_s1 <= mask_inversion_line_in;
            mi_s2 <= mi_s1;
            mode_s1 <= {write_mask_en, bus_inversion_en};
            mode_s2 <= mode_s1;
        end
    end

    assign die_rst = rst || !rstn_s[1];
    assign ck_rise = ck_t_s[1] && !ck_t_d && !ck_c_s[1];
    assign cmd_now = ck_rise ? ddl_cmd_t'(cmd_s2) : DDL_CMD_NOP;

    // Undo inversion on a received byte when the line flags it
    function automatic logic [LANE_W-1:0] lane_decode(input logic [LANE_W-1:0] b, input logic inv);
        lane_decode = inv ? ~b : b;
    endfunction

    // Array model, one word per address
    logic [DATA_W-1:0] mem [DEPTH];
    logic is_write;
    logic is_masked;
    assign is_write = (cmd_now == DDL_CMD_WRITE) || (cmd_now == DDL_CMD_MASKED_WRITE);
    assign is_masked = (cmd_now == DDL_CMD_MASKED_WRITE) && mode_s2[1];

    // write data is captured with the controller's strobe already ahead
    // One process owns the array; a process per lane would split its drivers
    always_ff @(posedge clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (is_write && !(is_masked && mi_s2[l])) begin
                mem[addr_s2][l*LANE_W +: LANE_W] <= lane_decode(dq_s2[l*LANE_W +: LANE_W],
                    mode_s2[0] && !is_masked && mi_s2[l]);
            end
        end
    end

    genvar g;

    // Read path through the two-entry buffer
    logic rd_push;
    logic rd_ready;
    logic rd_valid;
    logic [DATA_W-1:0] rd_word;
    logic rd_pop;
    ddl_state_t state;
    assign rd_push = (cmd_now == DDL_CMD_READ);
    assign rd_pop = rd_valid && (state == DDL_ST_IDLE);

    ddl_skid #(.WIDTH(DATA_W)) u_buf (
        .clk(clk),
        .rst(die_rst),
        .in_valid(rd_push),
        .in_ready(rd_ready),
        .in_data(mem[addr_s2]),
        .out_valid(rd_valid),
        .out_ready(rd_pop),
        .out_data(rd_word)
    );

    // strobe state: drive high then low with data
    always_ff @(posedge clk) begin
        if (die_rst) begin
            state <= DDL_ST_IDLE;
        end else begin
            case (state)
                DDL_ST_IDLE: if (rd_pop) state <= DDL_ST_STROBE_HI;
                DDL_ST_STROBE_HI: state <= DDL_ST_STROBE_LO;
                DDL_ST_STROBE_LO: state <= DDL_ST_IDLE;
                default: state <= DDL_ST_IDLE;
            endcase
        end
    end

    generate
        for (g = 0; g < LANES; g++) begin : g_rd
            always_ff @(posedge clk) begin
                if (die_rst) begin
                    dq_out[g*LANE_W +: LANE_W] <= '0;
                    dq_oe[g*LANE_W +: LANE_W] <= '0;
                    mask_inversion_line_out[g] <= 1'b0;
                    mask_inversion_line_oe[g] <= 1'b0;
                    dqs_t_out[g] <= 1'b0;
                    dqs_c_out[g] <= 1'b1;
                    dqs_oe[g] <= 1'b0;
                end else if (rd_pop) begin
                    // invert byte with more than four ones
                    if (mode_s2[0] && ($countones(rd_word[g*LANE_W +: LANE_W]) > 4)) begin
                        dq_out[g*LANE_W +: LANE_W] <= ~rd_word[g*LANE_W +: LANE_W];
                        mask_inversion_line_out[g] <= 1'b1;
                    end else begin
                        dq_out[g*LANE_W +: LANE_W] <= rd_word[g*LANE_W +: LANE_W];
                        mask_inversion_line_out[g] <= 1'b0;
                    end
                    dq_oe[g*LANE_W +: LANE_W] <= '1;
                    mask_inversion_line_oe[g] <= mode_s2[0];
                    dqs_oe[g] <= 1'b1;
                    dqs_t_out[g] <= 1'b1;
                    dqs_c_out[g] <= 1'b0;
                end else if (state == DDL_ST_STROBE_HI) begin
                    dqs_t_out[g] <= 1'b0;
                    dqs_c_out[g] <= 1'b1;
                end else if (state == DDL_ST_STROBE_LO) begin
                    // Release the bus after one full strobe period
                    dq_oe[g*LANE_W +: LANE_W] <= '0;
                    mask_inversion_line_oe[g] <= 1'b0;
                    dqs_oe[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Refresh timers; the controller keeps the spacing, we flag misses
    logic [CNT_W-1:0] ab_cnt;
    logic [CNT_W-1:0] sp_cnt;
    logic [CNT_W-1:0] pb_cnt [BANKS];
    logic bank_cmd;
    logic violation;
    assign bank_cmd = (cmd_now == DDL_CMD_READ) || is_write || (cmd_now == DDL_CMD_REF_BANK);
    assign violation = (cmd_now != DDL_CMD_NOP) && ((ab_cnt != CNT_RESET)
        || (bank_cmd && pb_cnt[bank_s2] != CNT_RESET)
        || (cmd_now == DDL_CMD_REF_BANK && sp_cnt != CNT_RESET)
        || (rd_push && !rd_ready));

    always_ff @(posedge clk) begin
        if (die_rst) begin
            ab_cnt <= CNT_RESET;
            sp_cnt <= CNT_RESET;
            timing_violation <= 1'b0;
        end else begin
            if (cmd_now == DDL_CMD_REF_ALL) ab_cnt <= CNT_W'(ALLBANK_CYC);
            else if (ab_cnt != CNT_RESET) ab_cnt <= ab_cnt - 5'h01;
            if (cmd_now == DDL_CMD_REF_BANK) sp_cnt <= CNT_W'(SPACING_CYC);
            else if (sp_cnt != CNT_RESET) sp_cnt <= sp_cnt - 5'h01;
            // Sticky so a short miss is seen
            if (violation) timing_violation <= 1'b1;
        end
    end

    generate
        for (g = 0; g < BANKS; g++) begin : g_pb
            always_ff @(posedge clk) begin
                if (die_rst) begin
                    pb_cnt[g] <= CNT_RESET;
                end else if (cmd_now == DDL_CMD_REF_BANK && bank_s2 == BANK_W'(g)) begin
                    pb_cnt[g] <= CNT_W'(PERBANK_CYC);
                end else if (pb_cnt[g] != CNT_RESET) begin
                    pb_cnt[g] <= pb_cnt[g] - 5'h01;
                end
            end
            assign bank_busy[g] = (pb_cnt[g] != CNT_RESET);
        end
    endgenerate

    assign allbank_busy = (ab_cnt != CNT_RESET);
endmodule

// ===== core/ddl_pkg.sv
// Purpose: Shared constants for the DRAM data lane and refresh timing block
// Assumes: 25 MHz system clock sampling a slower true clock input
// Notes: Refresh times are kept in ns and converted to cycles here
package ddl_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 6;
    localparam int DEPTH = 64;
    // Least times, rounded up to whole cycles
    localparam int ALLBANK_REFRESH_CYCLE_TIME_NS = 380;
    localparam int PERBANK_REFRESH_CYCLE_TIME_NS = 190;
    localparam int PERBANK_REFRESH_SPACING_NS = 90;
    localparam int ALLBANK_CYC = (ALLBANK_REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PERBANK_CYC = (PERBANK_REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPACING_CYC = (PERBANK_REFRESH_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;
    // Commands sampled at a true clock rising edge
    typedef enum logic [2:0] {
        DDL_CMD_NOP = 3'h0,
        DDL_CMD_WRITE = 3'h1,
        DDL_CMD_MASKED_WRITE = 3'h2,
        DDL_CMD_READ = 3'h3,
        DDL_CMD_REF_ALL = 3'h4,
        DDL_CMD_REF_BANK = 3'h5
    } ddl_cmd_t;
    typedef enum logic [1:0] {
        DDL_ST_IDLE = 2'h0,
        DDL_ST_STROBE_HI = 2'h1,
        DDL_ST_STROBE_LO = 2'h2
    } ddl_state_t;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
endpackage

// ===== core/ddl_skid.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock domain
// Notes: Ready on the fill side drops only when both entries hold data
`timescale 1ns/1ns
module ddl_skid #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    // Honest full and empty flags
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Storage and pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ===== tb/ddl_host_model.sv
// Purpose: Host controller model
// Assumes: Link clock stands low between commands
// Notes: Eight clk per command, 320 ns clock frame
`timescale 1ns/1ns
module ddl_host_model
    import ddl_pkg::*;
(
    // System clock
    input wire logic clk,
    // Link clock and command
    output logic true_clock_input,
    output logic complement_clock_input,
    output logic [2:0] cmd,
    output logic [BANK_W-1:0] bank,
    output logic [ADDR_W-1:0] addr,
    // Write side data
    output logic [DATA_W-1:0] dq_in,
    output logic [LANES-1:0] dqs_t_in,
    output logic [LANES-1:0] dqs_c_in,
    output logic [LANES-1:0] mask_inversion_line_in
);
    // Idle levels at time zero
    initial begin
        {true_clock_input, cmd, bank, addr, dq_in, dqs_t_in, mask_inversion_line_in} = '0;
        {complement_clock_input, dqs_c_in} = 3'h7;
    end
    task automatic issue(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic [LANES-1:0] m);
        @(posedge clk);
        {cmd, bank, addr} <= {c, b, a};
        {dqs_t_in, dqs_c_in} <= 4'hC;
        repeat (1) @(posedge clk);
        {dq_in, mask_inversion_line_in} <= {d, m};
        repeat (2) @(posedge clk);
        {true_clock_input, complement_clock_input} <= 2'h2;
        repeat (4) @(posedge clk);
        {true_clock_input, complement_clock_input, cmd} <= {2'h1, DDL_CMD_NOP};
        // Released lines show the inverse, never a stale value
        {dq_in, mask_inversion_line_in, dqs_t_in, dqs_c_in} <= {~d, ~m, 4'h3};
    endtask
endmodule

// ===== tb/ddl_lane_assertions.sv
// Purpose: Port checks on ddl_lane
// Assumes: One clk domain, rst sync high
// Notes: Bound to every ddl_lane
`timescale 1ns/1ns
module ddl_lane_assertions
    import ddl_pkg::*;
(
    // Clock, resets, link and mode
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic true_clock_input,
    input wire logic bus_inversion_en,
    // Outputs watched
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic [DATA_W-1:0] dq_oe,
    input wire logic [LANES-1:0] dqs_t_out,
    input wire logic [LANES-1:0] dqs_c_out,
    input wire logic [LANES-1:0] dqs_oe,
    input wire logic [LANES-1:0] mask_inversion_line_out,
    input wire logic [LANES-1:0] mask_inversion_line_oe,
    input wire logic allbank_busy,
    input wire logic [BANKS-1:0] bank_busy,
    input wire logic timing_violation
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Read start and strobe steps
    sequence s_rd;
        $rose(dqs_oe[0]);
    endsequence
    sequence s_strobe;
        dqs_t_out[0] && !dqs_c_out[0] ##1 !dqs_t_out[0] && dqs_c_out[0] ##1 !dqs_oe[0];
    endsequence
    property p_strobe; s_rd |-> s_strobe; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe shape");
    property p_align; s_rd |-> dq_oe == 16'hFFFF && $rose(dqs_oe[1]); endproperty
    a_align: assert property (p_align) else $error("lanes misaligned");
    // Inverted byte on the wire never has more than three ones
    property p_inv_pol;
        s_rd ##0 mask_inversion_line_oe[0] |-> $countones(dq_out[7:0]) < (mask_inversion_line_out[0] ? 4 : 5);
    endproperty
    a_inv_pol: assert property (p_inv_pol) else $error("line polarity");
    property p_no_inv; (!bus_inversion_en)[*8] |-> mask_inversion_line_oe == 2'h0; endproperty
    a_no_inv: assert property (p_no_inv) else $error("line driven");
    property p_allbank; $rose(allbank_busy) |-> allbank_busy[*8] ##1 allbank_busy[*2] ##1 !allbank_busy; endproperty
    a_allbank: assert property (p_allbank) else $error("allbank window");
    property p_perbank; $rose(bank_busy[0]) && !allbank_busy |-> bank_busy[0][*5] ##1 !bank_busy[0]; endproperty
    a_perbank: assert property (p_perbank) else $error("bank window");
    // Only reset clears the timing violation flag
    property p_sticky; disable iff (rst || !reset_pin_n) timing_violation |=> timing_violation; endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_pin;
        (!reset_pin_n)[*5] |-> !timing_violation && !allbank_busy && bank_busy == 8'h00 && dq_oe == 16'h0000;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset");
    property p_edge; (!true_clock_input)[*8] |-> !$rose(dqs_oe[0]) && !$rose(allbank_busy); endproperty
    a_edge: assert property (p_edge) else $error("no clock edge");
endmodule
bind ddl_lane ddl_lane_assertions u_chk (.clk, .rst, .reset_pin_n, .true_clock_input, .bus_inversion_en,
    .dq_out, .dq_oe, .dqs_t_out, .dqs_c_out, .dqs_oe, .mask_inversion_line_out, .mask_inversion_line_oe,
    .allbank_busy, .bank_busy, .timing_violation);

// ===== tb/ddl_lane_tb.sv
// Purpose: Self-checking bench for ddl_lane
// Assumes: Host model spaces commands eight clk apart
// Notes: Data traffic on eight addresses of bank 0
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module ddl_lane_tb
    import ddl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic bus_inversion_en = 1'b0;
    logic write_mask_en = 1'b0;
    logic true_clock_input, complement_clock_input, allbank_busy, timing_violation;
    logic [2:0] cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [BANKS-1:0] bank_busy;
    logic [DATA_W-1:0] dq_in, dq_out, dq_oe, cap_dq;
    logic [DATA_W-1:0] mem [8];
    logic [LANES-1:0] dqs_t_in, dqs_c_in, dqs_t_out, dqs_c_out, dqs_oe, cap_line, cap_loe;
    logic [LANES-1:0] mask_inversion_line_in, mask_inversion_line_out, mask_inversion_line_oe;
    logic cap_prev = 1'b0;
    int rd_cnt = 0;
    int failures = 0;
    int n_checks = 0;
    localparam logic [15:0] EDGE_W [4] = '{16'h0F1F, 16'hFF00, 16'h1FF0, 16'hE07F};
    // 25 MHz system clock
    always #20 clk = ~clk;
    ddl_lane u_dut (.clk, .rst, .reset_pin_n, .true_clock_input, .complement_clock_input, .cmd, .bank,
        .addr, .bus_inversion_en, .write_mask_en, .dq_in, .dq_out, .dq_oe, .dqs_t_in, .dqs_c_in, .dqs_t_out,
        .dqs_c_out, .dqs_oe, .mask_inversion_line_in, .mask_inversion_line_out, .mask_inversion_line_oe,
        .allbank_busy, .bank_busy, .timing_violation);
    ddl_host_model u_host (.clk, .true_clock_input, .complement_clock_input, .cmd, .bank, .addr, .dq_in,
        .dqs_t_in, .dqs_c_in, .mask_inversion_line_in);
    // Capture read beat when the strobe pair starts
    always @(posedge clk) begin
        cap_prev <= dqs_oe[0];
        if (dqs_oe[0] && !cap_prev) begin
            {cap_dq, cap_line, cap_loe} <= {dq_out, mask_inversion_line_out, mask_inversion_line_oe};
            rd_cnt <= rd_cnt + 1;
        end
    end
    // Expected wire line and byte of a read
    function automatic logic [8:0] rd_lane(input logic [7:0] v, input logic inv);
        return (inv && $countones(v) > 4) ? {1'b1, ~v} : {1'b0, v};
    endfunction
    // Stored byte after a write
    function automatic logic [7:0] wr_lane(input logic [7:0] o, input logic [7:0] d, input logic m,
            input logic [2:0] c, input logic inv, input logic men);
        // With masking off a masked write is an ordinary write
        if (c == DDL_CMD_MASKED_WRITE && men) return m ? o : d;
        return (inv && m) ? ~d : d;
    endfunction
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One data command on bank 0, read compared on its strobe
    task automatic op(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d, input logic [1:0] m);
        int n;
        logic [8:0] e;
        n = rd_cnt;
        u_host.issue(c, 3'h0, {3'h0, a}, d, m);
        for (int k = 0; k < 8 && c == DDL_CMD_READ && rd_cnt == n; k++) @(posedge clk);
        if (c == DDL_CMD_READ && rd_cnt == n) begin
            failures++;
            end_sim();
        end
        for (int l = 0; l < LANES; l++) begin
            e = rd_lane(mem[a][8*l +: 8], bus_inversion_en);
            if (c == DDL_CMD_READ) begin
                `CHK(cap_dq[8*l +: 8], e[7:0])
                `CHK({cap_line[l], cap_loe[l]}, {e[8], bus_inversion_en})
            end else begin
                mem[a][8*l +: 8] = wr_lane(mem[a][8*l +: 8], d[8*l +: 8], m[l], c, bus_inversion_en, write_mask_en);
            end
        end
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_sim();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h03DD8E36));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) op(DDL_CMD_WRITE, 3'(i), EDGE_W[i % 4], 2'h0);
        $display("test fill done");
        repeat (60) begin
            bus_inversion_en <= 1'($urandom);
            write_mask_en <= 1'($urandom);
            op(3'($urandom_range(3, 1)), 3'($urandom), 16'($urandom), 2'($urandom));
        end
        $display("test random done");
        u_host.issue(DDL_CMD_REF_BANK, 3'h0, 6'h00, 16'h0000, 2'h0);
        op(DDL_CMD_READ, 3'h0, 16'h0000, 2'h0);
        u_host.issue(DDL_CMD_REF_BANK, 3'h1, 6'h00, 16'h0000, 2'h0);
        u_host.issue(DDL_CMD_REF_BANK, 3'h2, 6'h00, 16'h0000, 2'h0);
        u_host.issue(DDL_CMD_REF_ALL, 3'h0, 6'h00, 16'h0000, 2'h0);
        repeat (9) @(posedge clk);
        op(DDL_CMD_READ, 3'h1, 16'h0000, 2'h0);
        `CHK(timing_violation, 1'b0)
        u_host.issue(DDL_CMD_REF_ALL, 3'h0, 6'h00, 16'h0000, 2'h0);
        op(DDL_CMD_READ, 3'h2, 16'h0000, 2'h0);
        `CHK(timing_violation, 1'b1)
        $display("test refresh done");
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK({timing_violation, dq_oe}, 17'h00000)
        op(DDL_CMD_READ, 3'h3, 16'h0000, 2'h0);
        $display("test pin reset done");
        end_sim();
    end
endmodule
